// >>> src/hscl_defines.svh
`ifndef HSCL_DEFINES_SVH
`define HSCL_DEFINES_SVH
// register word indexes, not byte addresses (byte address is index*4)
`define HSCL_IDX_CTRL 8'h00
`define HSCL_IDX_OUTA 8'h01
`define HSCL_IDX_OUTB 8'h02
`define HSCL_IDX_TAMP 8'h03
`define HSCL_IDX_FILT 8'h04
`define HSCL_IDX_MISC 8'h05
`define HSCL_IDX_DATA 8'h06
`define HSCL_IDX_STAT 8'h07
`define HSCL_IDX_START 8'h08
// ctrl fields
`define HSCL_CTRL_SLEEP 0
`define HSCL_CTRL_ITMR 1
// outb fields
`define HSCL_OUTB_LATCH 0
`define HSCL_OUTB_POLHI 1
`define HSCL_OUTB_OMNI 2
`define HSCL_OUTB_TEN 3
// misc fields
`define HSCL_MISC_COIL_EN 0
`define HSCL_MISC_COIL_NEG 1
// reset values
`define HSCL_RST_CTRL 32'h0000_0000
`define HSCL_RST_OUTA 32'h0000_0100
`define HSCL_RST_OUTB 32'h0000_0016
`define HSCL_RST_TAMP 32'h0000_7000
`define HSCL_RST_FILT 32'h0000_0404
`define HSCL_RST_MISC 32'h0000_0000
`define HSCL_COIL_SHIFT 16'h0040
`define HSCL_ITMR_CYC 32'h0000_0400
`define HSCL_SAMP_CYC 8'h04
`define HSCL_RESP_OKAY 2'b00
`define HSCL_RESP_SLVERR 2'b10
`endif

// >>> src/hscl_pkg.sv
package hscl_pkg;
  typedef enum logic [1:0] {
    HSCL_IDLE,
    HSCL_SAMPLE,
    HSCL_DONE
  } hscl_state_type;
endpackage

// >>> src/hscl_top.sv
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`include "hscl_defines.svh"
module hscl_top
  import hscl_pkg::*;
#(
  parameter int ITMR_PERIOD = 1024
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // field samples from the front end (same clock)
  input wire logic signed [15:0] fe_field,
  input wire logic fe_valid,
  // sensor output pin
  output logic pin_out,
  // axi4-lite write address
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // axi4-lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // axi4-lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read address
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // axi4-lite read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  logic [31:0] ctrl_r, outa_r, outb_r, tamp_r, filt_r, misc_r;
  logic signed [15:0] data_r;
  logic signed [23:0] acc_r;
  logic [7:0] cnt_r;
  logic [31:0] tmr_r;
  logic busy_r, fresh_r;
  hscl_state_type st_r;
  logic aw_got_r, w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [7:0] widx(input logic [7:0] a);
    return {2'b00, a[7:2]};
  endfunction

  // decode
  wire sleep_mode = ctrl_r[`HSCL_CTRL_SLEEP];
  wire itmr_mode = ctrl_r[`HSCL_CTRL_ITMR];
  wire aw_now = s_awvalid && s_awready;
  wire w_now = s_wvalid && s_wready;
  wire have_aw = aw_got_r || aw_now;
  wire have_w = w_got_r || w_now;
  wire do_wr = have_aw && have_w && !s_bvalid;
  wire [7:0] wa = aw_got_r ? awaddr_r : s_awaddr;
  wire [31:0] wd = w_got_r ? wdata_r : s_wdata;
  wire [3:0] ws = w_got_r ? wstrb_r : s_wstrb;
  wire [7:0] wi = widx(wa);
  wire wr_out = (wi == `HSCL_IDX_OUTA) || (wi == `HSCL_IDX_OUTB);
  wire wr_known = wi <= `HSCL_IDX_START && wi != `HSCL_IDX_DATA &&
                  wi != `HSCL_IDX_STAT;
  wire wr_ok = wr_known && (!sleep_mode || wr_out ||
               wi == `HSCL_IDX_CTRL);
  wire wr_en = do_wr && wr_ok;
  wire host_start = wr_en && wi == `HSCL_IDX_START && !itmr_mode;
  wire tmr_start = itmr_mode && !sleep_mode &&
                   tmr_r >= 32'(ITMR_PERIOD - 1);
  wire sleep_start = sleep_mode && tmr_r >= 32'(ITMR_PERIOD - 1);
  wire start = (host_start || tmr_start || sleep_start) && !busy_r;
  wire iir_sel = filt_r[0];
  wire [7:0] nsamp = iir_sel ? filt_r[15:8] : filt_r[7:0];
  wire [7:0] nlim = (nsamp == 8'h00) ? 8'h01 : nsamp;
  wire signed [15:0] coil = misc_r[`HSCL_MISC_COIL_EN] ?
    (misc_r[`HSCL_MISC_COIL_NEG] ? -$signed(`HSCL_COIL_SHIFT) :
     $signed(`HSCL_COIL_SHIFT)) : 16'sd0;
  wire signed [15:0] smp = fe_field + coil;
  // full-width sum, divided by the programmed count so any count averages
  wire signed [23:0] acc_nxt = acc_r + 24'(smp);
  wire last = st_r == HSCL_SAMPLE && fe_valid && cnt_r + 8'h01 >= nlim;
  wire signed [23:0] quo = acc_nxt / $signed({16'h0000, nlim});
  wire signed [15:0] avg = quo[15:0];
  wire signed [15:0] iir_nxt = data_r + ((avg - data_r) >>> 2);
  wire signed [15:0] res = iir_sel ? iir_nxt : avg;
  // comparison
  wire omni = outb_r[`HSCL_OUTB_OMNI];
  // tamper always looks at the magnitude, whatever the symmetry
  wire [15:0] absf = res[15] ? 16'(-res) : res;
  wire [15:0] mag = omni ? absf : res;
  wire signed [15:0] fv = omni ? $signed(mag) : res;
  wire signed [15:0] swp = $signed(outa_r[15:0]);
  wire signed [15:0] hys = $signed({8'h00, outa_r[23:16]});
  logic act_r;
  wire act_nxt = outb_r[`HSCL_OUTB_LATCH] ?
    (fv >= swp ? 1'b1 : (fv <= -swp ? 1'b0 : act_r)) :
    (fv >= swp ? 1'b1 : (fv < swp - hys ? 1'b0 : act_r));
  wire tamp_hit = outb_r[`HSCL_OUTB_TEN] &&
                  absf >= tamp_r[15:0];
  wire pol = outb_r[`HSCL_OUTB_POLHI];
  wire pin_nxt = tamp_hit ? !pol : (act_nxt ? pol : !pol);

  // read decode
  wire [7:0] ri = widx(s_araddr);
  logic [31:0] rd_mux;
  logic rd_err;
  always_comb begin
    rd_err = 1'b0;
    case (ri)
      `HSCL_IDX_CTRL: rd_mux = ctrl_r;
      `HSCL_IDX_OUTA: rd_mux = outa_r;
      `HSCL_IDX_OUTB: rd_mux = outb_r;
      `HSCL_IDX_TAMP: rd_mux = tamp_r;
      `HSCL_IDX_FILT: rd_mux = filt_r;
      `HSCL_IDX_MISC: rd_mux = misc_r;
      `HSCL_IDX_DATA: rd_mux = sleep_mode ? 32'h0000_0000 :
                               32'(unsigned'(data_r));
      `HSCL_IDX_STAT: rd_mux = {29'h0, pin_out, fresh_r, busy_r};
      `HSCL_IDX_START: rd_mux = 32'h0000_0000;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end

  // write channel
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= `HSCL_RESP_OKAY;
    end else begin
      if (aw_now) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_awaddr;
      end
      if (w_now) begin
        w_got_r <= 1'b1;
        wdata_r <= s_wdata;
        wstrb_r <= s_wstrb;
      end
      s_awready <= !have_aw && !s_bvalid && !s_awready;
      s_wready <= !have_w && !s_bvalid && !s_wready;
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? `HSCL_RESP_OKAY : `HSCL_RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r <= `HSCL_RST_CTRL;
      outa_r <= `HSCL_RST_OUTA;
      outb_r <= `HSCL_RST_OUTB;
      tamp_r <= `HSCL_RST_TAMP;
      filt_r <= `HSCL_RST_FILT;
      misc_r <= `HSCL_RST_MISC;
    end else if (wr_en) begin
      case (wi)
        `HSCL_IDX_CTRL: ctrl_r <= merge(ctrl_r, wd, ws) & 32'h0000_0003;
        `HSCL_IDX_OUTA: outa_r <= merge(outa_r, wd, ws) & 32'h00FF_FFFF;
        `HSCL_IDX_OUTB: outb_r <= merge(outb_r, wd, ws) & 32'h0000_000F;
        `HSCL_IDX_TAMP: tamp_r <= merge(tamp_r, wd, ws) & 32'h0000_FFFF;
        `HSCL_IDX_FILT: filt_r <= merge(filt_r, wd, ws) & 32'h0000_FFFF;
        `HSCL_IDX_MISC: misc_r <= merge(misc_r, wd, ws) & 32'h0000_0003;
        default: ;
      endcase
    end
  end

  // read channel
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= `HSCL_RESP_OKAY;
    end else begin
      s_arready <= !s_rvalid && !s_arready;
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_mux;
        s_rresp <= rd_err ? `HSCL_RESP_SLVERR : `HSCL_RESP_OKAY;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // conversion engine
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= HSCL_IDLE;
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      acc_r <= 24'sd0;
      data_r <= 16'sd0;
      tmr_r <= 32'h0000_0000;
      fresh_r <= 1'b0;
      act_r <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      tmr_r <= (tmr_start || sleep_start || !(itmr_mode || sleep_mode)) ?
               32'h0000_0000 : tmr_r + 32'h0000_0001;
      if (s_arvalid && s_arready && ri == `HSCL_IDX_DATA) fresh_r <= 1'b0;
      case (st_r)
        HSCL_IDLE: begin
          if (start) begin
            st_r <= HSCL_SAMPLE;
            busy_r <= 1'b1;
            cnt_r <= 8'h00;
            acc_r <= 24'sd0;
          end
        end
        HSCL_SAMPLE: begin
          if (fe_valid) begin
            acc_r <= acc_nxt;
            cnt_r <= cnt_r + 8'h01;
          end
          if (last) begin
            st_r <= HSCL_DONE;
            data_r <= res;
            act_r <= act_nxt;
            pin_out <= pin_nxt;
          end
        end
        HSCL_DONE: begin
          busy_r <= 1'b0;
          fresh_r <= 1'b1;
          st_r <= HSCL_IDLE;
        end
        default: st_r <= HSCL_IDLE;
      endcase
    end
  end
endmodule

// >>> dv/hscl_chk.sv
module hscl_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // write side
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  // read side
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  input wire logic s_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic aw_r, w_r;
  // remember taken write halves until the response
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
    end else if (s_bvalid && s_bready) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
    end else begin
      aw_r <= aw_r | (s_awvalid & s_awready);
      w_r <= w_r | (s_wvalid & s_wready);
    end
  end
  sequence ar_take;
    s_arvalid && s_arready;
  endsequence
  sequence both_taken;
    aw_r && w_r;
  endsequence
  wr_answer_a: assert property (both_taken |-> ##[0:1] s_bvalid)
    else $error("write response late");
  wr_cause_a: assert property ($rose(s_bvalid) |-> aw_r && w_r)
    else $error("write response without request");
  rd_answer_a: assert property (ar_take |=> s_rvalid)
    else $error("read data late");
  rd_cause_a: assert property ($rose(s_rvalid) |-> $past(s_arready))
    else $error("read data without request");
  unmapped_rd_a: assert property (ar_take and s_araddr[7:2] > 6'h08
    |=> s_rresp == 2'b10 && s_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  b_hold_a: assert property (s_bvalid && !s_bready
    |=> s_bvalid && $stable(s_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_rvalid && !s_rready
    |=> s_rvalid && $stable(s_rdata)) else $error("rdata dropped");
  aw_pulse_a: assert property (s_awready |=> !s_awready)
    else $error("awready held");
  ar_pulse_a: assert property (s_arready |=> !s_arready)
    else $error("arready held");
endmodule

// >>> dv/hscl_fe_model.sv
module hscl_fe_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // field to present
  input wire logic signed [15:0] field,
  // front end samples
  output logic signed [15:0] fe_field,
  output logic fe_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // a sample every other cycle, garbage in between
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fe_valid <= 1'b0;
      fe_field <= 16'h0000;
    end else begin
      fe_valid <= !fe_valid;
      fe_field <= fe_valid ? ~field : field;
    end
  end
endmodule

// >>> dv/hscl_tb.sv
`include "hscl_defines.svh"
module hscl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CT = 8'h00, OA = 8'h04, OB = 8'h08, TP = 8'h0c;
  localparam logic [7:0] FI = 8'h10, MI = 8'h14, DA = 8'h18, ST = 8'h1c;
  logic clk_sys = 0, rst = 1, fe_valid, pin_out;
  logic signed [15:0] field = 0, fe_field;
  logic [7:0] s_awaddr = 0, s_araddr = 0;
  logic [31:0] s_wdata = 0, s_rdata, rd;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
  logic s_rready = 0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  int n_fail = 0, total_checks = 0;
  always #2 clk_sys = ~clk_sys;
  hscl_fe_model FE (.clk_sys, .rst, .field, .fe_field, .fe_valid);
  hscl_top #(.ITMR_PERIOD(8)) DUT (.clk_sys, .rst, .fe_field, .fe_valid,
    .pin_out, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
  task tally_and_finish;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge clk_sys);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1;
    s_wvalid <= 1;
    s_bready <= 1;
    for (n = 0; n < 99; n++) begin
      @(posedge clk_sys);
      if (s_awready) s_awvalid <= 0;
      if (s_wready) s_wvalid <= 0;
      if (s_bvalid) break;
    end
    s_bready <= 0;
    if (n == 99) begin
      n_fail++;
      tally_and_finish;
    end
    chk("bresp", s_bresp, e);
  endtask
  task rdw(input logic [7:0] a, input logic [1:0] e);
    int n;
    @(posedge clk_sys);
    s_araddr <= a;
    s_arvalid <= 1;
    s_rready <= 1;
    for (n = 0; n < 99; n++) begin
      @(posedge clk_sys);
      if (s_arready) s_arvalid <= 0;
      if (s_rvalid) break;
    end
    s_rready <= 0;
    if (n == 99) begin
      n_fail++;
      tally_and_finish;
    end
    rd = s_rdata;
    chk("rresp", s_rresp, e);
  endtask
  task conv(input logic signed [15:0] f, input logic p);
    int n;
    field <= f;
    wr(8'h20, 32'h0000_0001, 2'b00);
    for (n = 0; n < 99; n++) begin
      rdw(ST, 2'b00);
      if (rd[0] === 1'b0) break;
    end
    chk("pin", pin_out, p);
  endtask
  task wp(input logic signed [15:0] f, input logic p);
    int n;
    field <= f;
    for (n = 0; n < 500 && pin_out !== p; n++) @(posedge clk_sys);
    chk("pin", pin_out, p);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    rdw(OA, 2'b00); chk("outa", rd, `HSCL_RST_OUTA);
    rdw(OB, 2'b00); chk("outb", rd, `HSCL_RST_OUTB);
    rdw(8'h40, 2'b10); chk("unmapped", rd, 32'h0000_0000);
    wr(DA, 32'h0000_0001, 2'b10);
    rdw(FI, 2'b00); chk("filt", rd, `HSCL_RST_FILT);
    wr(FI, {rd[31:16], 16'h0808}, 2'b00);
    wr(OA, 32'h0010_0064, 2'b00);
    wr(OB, 32'h0000_0002, 2'b00);
    $display("test config done");
    conv(200, 1);
    rdw(DA, 2'b00); chk("data", rd[15:0], 16'h00c8);
    conv(90, 1);
    conv(83, 0);
    wr(MI, 32'h0000_0001, 2'b00);
    conv(100, 1);
    rdw(DA, 2'b00); chk("coil up", rd[15:0], 16'h00a4);
    wr(MI, 32'h0000_0003, 2'b00);
    conv(100, 0);
    rdw(DA, 2'b00); chk("coil dn", rd[15:0], 16'h0024);
    wr(MI, 32'h0000_0000, 2'b00);
    wr(OB, 32'h0000_0003, 2'b00);
    conv(-200, 0);
    conv(200, 1);
    conv(0, 1);
    wr(OB, 32'h0000_0006, 2'b00);
    conv(-200, 1);
    wr(OB, 32'h0000_0004, 2'b00);
    conv(-200, 0);
    wr(OB, 32'h0000_000a, 2'b00);
    wr(TP, 32'h0000_012c, 2'b00);
    conv(200, 1);
    conv(400, 0);
    $display("test compare done");
    wr(CT, 32'h0000_0001, 2'b00);
    wr(FI, 32'h0000_0404, 2'b10);
    wr(OB, 32'h0000_0002, 2'b00);
    rdw(DA, 2'b00); chk("sleep data", rd, 32'h0000_0000);
    wp(-50, 0);
    wp(200, 1);
    wr(CT, 32'h0000_0002, 2'b00);
    wp(-50, 0);
    wr(CT, 32'h0000_0000, 2'b00);
    $display("test modes done");
    tally_and_finish;
  end
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
endmodule
bind hscl_top hscl_chk CHK (.clk_sys, .rst, .s_awvalid, .s_awready,
  .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
  .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
